// [srtc_defs.vh]
/*
  srtc_defs.vh: offsets, field positions, reset values and timing counts
  for the serial real-time clock block.
  assumes: included by bare name from the design file; 25 MHz system clock.
*/
`ifndef SRTC_DEFS_VH
`define SRTC_DEFS_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define SRTC_OFS_SECONDS 6'h00
`define SRTC_OFS_MINUTES 6'h01
`define SRTC_OFS_HOURS 6'h02
`define SRTC_OFS_WEEKDAY 6'h03
`define SRTC_OFS_MDAY 6'h04
`define SRTC_OFS_MONTH 6'h05
`define SRTC_OFS_YEAR 6'h06
`define SRTC_OFS_CONTROL 6'h07
`define SRTC_OFS_RAM_FIRST 6'h08
`define SRTC_OFS_RAM_LAST 6'h3f

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define SRTC_SEC_HALT_BIT 7
`define SRTC_HR_12H_BIT 6
`define SRTC_HR_PM_BIT 5
`define SRTC_CTL_OUT_BIT 7
`define SRTC_CTL_OSF_BIT 5
`define SRTC_CTL_SQUARE_WAVE_ENABLE_BIT 4
`define SRTC_CTL_RESET 8'hb3
`define SRTC_CTL_WMASK 8'h93
`define SRTC_DEV_ADDR 7'h68

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SRTC_CLK_HZ 25000000
`define SRTC_OSC_HZ 32768
`define SRTC_TIMEOUT_MS 35
`define SRTC_TIMEOUT_CYC (`SRTC_TIMEOUT_MS * (`SRTC_CLK_HZ / 1000))
`define SRTC_FIFO_DEPTH 16

`endif

// [srtc_top.v]
/*
  srtc_top.v: two-wire serial slave, timekeeping counters, control and
  user ram of a serial real-time clock, plus its write-data fifo.
  assumes: clk 25 MHz; scl/sda/osc_clk asynchronous pins, synchronised
  here; the bench resolves the open-drain sda from sda_oe.
*/
`timescale 1ns/100ps
`include "srtc_defs.vh"

// ---------------------------------------------------------------
// fifo
// ---------------------------------------------------------------
module srtc_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk, // system clock
  input wire srst, // sync reset
  input wire ce, // clock enable
  input wire in_valid, // write request
  output wire in_ready, // room left
  input wire [WIDTH-1:0] in_data, // write word
  output wire out_valid, // word waiting
  input wire out_ready, // drain request
  output wire [WIDTH-1:0] out_data // head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  wire push;
  wire pop;
  assign in_ready = (cnt != DEPTH[AW:0]);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data = mem[rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // pointers wrap naturally since depth is a power of two
  always @(posedge clk) begin
    if (srst) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem[wp] <= in_data;
        wp <= wp + 1'b1;
      end
      if (pop)
        rp <= rp + 1'b1;
      if (push & ~pop)
        cnt <= cnt + 1'b1;
      else if (pop & ~push)
        cnt <= cnt - 1'b1;
    end
  end
endmodule // srtc_fifo

// ---------------------------------------------------------------
// top
// ---------------------------------------------------------------
module srtc_top #(
  parameter TIMEOUT_CYC = `SRTC_TIMEOUT_CYC
) (
  input wire clk, // system clock
  input wire srst, // sync reset
  input wire ce, // clock enable
  input wire osc_clk, // 32.768 khz oscillator
  input wire scl_in, // bus clock pin
  input wire sda_in, // bus data pin level
  output reg sda_out, // bus data drive value
  output reg sda_oe, // bus data pull enable
  output reg square_wave_pin, // square wave / level out
  output wire wr_fifo_full // write fifo back-pressure
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_RACK = 3'd4;
  localparam ST_TX = 3'd5;
  localparam ST_TACK = 3'd6;

  reg [7:0] regs [0:63];
  reg [7:0] snap [0:6];
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg [2:0] osc_s;
  reg [2:0] state;
  reg [3:0] bitn;
  reg [7:0] shreg;
  reg [5:0] ptr;
  reg ptr_loaded;
  reg [31:0] tmo;
  reg [14:0] div;
  reg halted_q;
  reg seconds_wr;
  reg [7:0] txbyte;
  integer i;
  integer j;

  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c = scl & scl_s[2] & sda_s[2] & ~sda;
  wire stop_c = scl & scl_s[2] & ~sda_s[2] & sda;
  wire osc_rise = osc_s[1] & ~osc_s[2];
  wire halted = regs[`SRTC_OFS_SECONDS][`SRTC_SEC_HALT_BIT];
  wire [5:0] ptr_nx = (ptr == `SRTC_OFS_RAM_LAST) ? 6'h00 : ptr + 6'h01;
  wire tick = ~halted & osc_rise & (div == 15'h7fff);

  // write fifo: {addr, data} from bus to register commit
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [13:0] fifo_out_data;
  wire fifo_drain = ~tick; // writes stall for the tick cycle
  assign wr_fifo_full = ~fifo_in_ready;
  srtc_fifo #(.WIDTH(14), .DEPTH(`SRTC_FIFO_DEPTH), .AW(4)) u_fifo (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({ptr, shreg}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_drain),
    .out_data(fifo_out_data)
  );
  // byte queued when the ack pulse starts
  assign fifo_in_valid = (state == ST_RACK) && scl_rise && ptr_loaded && ~start_c;

  // bcd increment with wrap to a floor value
  function [7:0] bcd_inc;
    input [7:0] v;
    input [7:0] maxv;
    input [7:0] minv;
    begin
      if (v >= maxv)
        bcd_inc = minv;
      else if (v[3:0] >= 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last day of month in bcd, leap year every fourth year
  function [7:0] month_end;
    input [7:0] mon;
    input [7:0] yr;
    begin
      if (mon == 8'h02)
        month_end = ((yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
          (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8))) ? 8'h29 : 8'h28;
      else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11)
        month_end = 8'h30;
      else
        month_end = 8'h31;
    end
  endfunction

  // masks fixed-zero bits of a write
  function [7:0] wmask;
    input [5:0] a;
    begin
      if (a == `SRTC_OFS_MINUTES)
        wmask = 8'h7f;
      else if (a == `SRTC_OFS_HOURS)
        wmask = 8'h7f;
      else if (a == `SRTC_OFS_WEEKDAY)
        wmask = 8'h07;
      else if (a == `SRTC_OFS_MDAY)
        wmask = 8'h3f;
      else if (a == `SRTC_OFS_MONTH)
        wmask = 8'h1f;
      else if (a == `SRTC_OFS_CONTROL)
        wmask = `SRTC_CTL_WMASK;
      else
        wmask = 8'hff;
    end
  endfunction

  // next hour in each format; format and pm flags are spliced back on commit
  wire [7:0] hr12_nx = bcd_inc({3'b000, regs[2][4:0]}, 8'h12, 8'h01);
  wire [7:0] hr24_nx = bcd_inc({2'b00, regs[2][5:0]}, 8'h23, 8'h00);

  // pin synchronisers; only stage 1 and 2 feed logic
  always @(posedge clk) begin
    if (srst) begin
      scl_s <= 3'b111;
      sda_s <= 3'b111;
      osc_s <= 3'b000;
    end else if (ce) begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      osc_s <= {osc_s[1:0], osc_clk};
    end
  end

  // read byte source: snapshot for time, live for control and ram
  always @* begin
    if (ptr <= `SRTC_OFS_YEAR)
      txbyte = snap[ptr[2:0]];
    else
      txbyte = regs[ptr];
  end

  // serial slave engine
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      bitn <= 4'd0;
      shreg <= 8'h00;
      ptr <= 6'h00;
      ptr_loaded <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      tmo <= 32'd0;
    end else if (ce) begin
      if (scl || state == ST_IDLE)
        tmo <= 32'd0;
      else
        tmo <= tmo + 32'd1;
      if (start_c) begin
        state <= ST_ADDR;
        bitn <= 4'd0;
        sda_oe <= 1'b0;
      end else if (stop_c || tmo >= TIMEOUT_CYC) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              bitn <= bitn + 4'd1;
            end else if (scl_fall && bitn == 4'd8) begin
              bitn <= 4'd0;
              if (state == ST_ADDR && shreg[7:1] != `SRTC_DEV_ADDR) begin
                state <= ST_IDLE;
              end else begin
                sda_oe <= 1'b1;
                state <= (state == ST_ADDR) ? ST_AACK : ST_RACK;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              ptr_loaded <= 1'b0;
              if (shreg[0]) begin
                state <= ST_TX;
                sda_oe <= ~txbyte[7];
                shreg <= {txbyte[6:0], 1'b0};
                bitn <= 4'd1;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_RX;
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= ST_RX;
              if (~ptr_loaded) begin
                ptr <= shreg[5:0];
                ptr_loaded <= 1'b1;
              end else begin
                ptr <= ptr_nx;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitn == 4'd8) begin
                sda_oe <= 1'b0;
                state <= ST_TACK;
                ptr <= ptr_nx;
              end else begin
                sda_oe <= ~shreg[7];
                shreg <= {shreg[6:0], 1'b0};
                bitn <= bitn + 4'd1;
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              shreg[0] <= sda;
            end else if (scl_fall) begin
              if (shreg[0]) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_TX;
                sda_oe <= ~txbyte[7];
                shreg <= {txbyte[6:0], 1'b0};
                bitn <= 4'd1;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // snapshot on start, stop and pointer wrap to zero
  always @(posedge clk) begin
    if (srst) begin
      for (j = 0; j < 7; j = j + 1)
        snap[j] <= 8'h00;
    end else if (ce) begin
      if (start_c || stop_c || (scl_fall && ptr_nx == 6'h00 &&
          ((state == ST_TX && bitn == 4'd8) || (state == ST_RACK && ptr_loaded)))) begin
        for (j = 0; j < 7; j = j + 1)
          snap[j] <= regs[j];
      end
    end
  end

  // timekeeping, sub-second divider and register commits
  always @(posedge clk) begin
    if (srst) begin
      for (i = 0; i < 64; i = i + 1)
        regs[i] <= 8'h00;
      regs[`SRTC_OFS_SECONDS] <= 8'h80;
      regs[`SRTC_OFS_WEEKDAY] <= 8'h01;
      regs[`SRTC_OFS_MDAY] <= 8'h01;
      regs[`SRTC_OFS_MONTH] <= 8'h01;
      regs[`SRTC_OFS_CONTROL] <= `SRTC_CTL_RESET;
      div <= 15'h0000;
      halted_q <= 1'b1;
      seconds_wr <= 1'b0;
    end else if (ce) begin
      halted_q <= halted;
      seconds_wr <= 1'b0;
      if (halted)
        div <= 15'h0000;
      else if (osc_rise)
        div <= div + 15'h0001;
      if (tick) begin
        regs[0] <= bcd_inc(regs[0], 8'h59, 8'h00);
        if (regs[0] == 8'h59) begin
          regs[1] <= bcd_inc(regs[1], 8'h59, 8'h00);
          if (regs[1] == 8'h59) begin
            if (regs[2][`SRTC_HR_12H_BIT]) begin
              if (regs[2][4:0] == 5'h12)
                regs[2] <= {regs[2][7:5], 5'h01};
              else if (regs[2][4:0] == 5'h11)
                regs[2] <= {regs[2][7:6], ~regs[2][5], 5'h12};
              else
                regs[2] <= {regs[2][7:5], hr12_nx[4:0]}; // keeps format and pm
            end else begin
              regs[2] <= {2'b00, hr24_nx[5:0]};
            end
            if ((regs[2][6] && regs[2][5:0] == 6'h31) ||
                (~regs[2][6] && regs[2][5:0] == 6'h23)) begin
              regs[3] <= bcd_inc(regs[3], 8'h07, 8'h01);
              regs[4] <= bcd_inc(regs[4], month_end(regs[5], regs[6]), 8'h01);
              if (regs[4] >= month_end(regs[5], regs[6])) begin
                regs[5] <= bcd_inc(regs[5], 8'h12, 8'h01);
                if (regs[5] == 8'h12)
                  regs[6] <= bcd_inc(regs[6], 8'h99, 8'h00);
              end
            end
          end
        end
      end else if (fifo_out_valid) begin
        if (fifo_out_data[13:8] == `SRTC_OFS_CONTROL) begin
          // stop flag may only be cleared by software
          regs[7] <= (fifo_out_data[7:0] & `SRTC_CTL_WMASK) |
            (regs[7] & fifo_out_data[7:0] & 8'h20);
        end else begin
          regs[fifo_out_data[13:8]] <= fifo_out_data[7:0] & wmask(fifo_out_data[13:8]);
        end
        if (fifo_out_data[13:8] == `SRTC_OFS_SECONDS) begin
          div <= 15'h0000;
          seconds_wr <= 1'b1;
        end
      end
      // set wins over a clear landing in the same cycle
      if (halted && !halted_q)
        regs[7][`SRTC_CTL_OSF_BIT] <= 1'b1;
    end
  end

  // square-wave output; bit 14 of the divider is high from 500ms on
  always @(posedge clk) begin
    if (srst) begin
      square_wave_pin <= 1'b1;
    end else if (ce) begin
      if (!regs[7][`SRTC_CTL_SQUARE_WAVE_ENABLE_BIT])
        square_wave_pin <= regs[7][`SRTC_CTL_OUT_BIT];
      else if (halted)
        square_wave_pin <= 1'b0;
      else begin
        case (regs[7][1:0])
          2'b00: square_wave_pin <= div[14];
          2'b01: square_wave_pin <= div[2];
          2'b10: square_wave_pin <= div[1];
          default: square_wave_pin <= osc_s[1];
        endcase
      end
    end
  end
endmodule // srtc_top

// [srtc_props.sv]
/* srtc_props.sv: port checker for srtc_top, bound below.
   assumes: one clk domain, srst sync high, sda_in is the resolved line. */
`timescale 1ns/100ps
// ------------------------------------------------
// checker
// ------------------------------------------------
module srtc_props #(
  parameter TIMEOUT_CYC = 2000
) (
  input wire clk, // system clock
  input wire srst, // sync reset
  input wire ce, // clock enable
  input wire osc_clk, // oscillator
  input wire scl_in, // bus clock
  input wire sda_in, // bus data
  input wire sda_out, // drive value
  input wire sda_oe, // pull enable
  input wire square_wave_pin, // square wave out
  input wire wr_fifo_full // fifo full
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  int unsigned low_cnt;

  // scl low run length, saturating so it never wraps
  always @(posedge clk) begin
    if (srst || scl_in) begin
      low_cnt <= 0;
    end else if (low_cnt < TIMEOUT_CYC + 16) begin
      low_cnt <= low_cnt + 1;
    end
  end

  a_drive_zero: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("sda drive moved with scl high");
  a_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("sda pull dropped early");
  a_start_quiet: assert property ($fell(sda_in) && scl_in && $past(scl_in) |-> !sda_oe [*8])
    else $error("sda driven after start");
  a_stop_quiet: assert property ($rose(sda_in) && scl_in && $past(scl_in) |-> !sda_oe [*8])
    else $error("sda driven after stop");
  a_halt_quiet: assert property ($fell(srst) |=> !square_wave_pin [*8])
    else $error("square wave active while halted");
  a_fifo_free: assert property (!wr_fifo_full)
    else $error("write fifo backed up");
  a_timeout_drop: assert property (low_cnt == TIMEOUT_CYC + 8 |-> !sda_oe)
    else $error("sda held past timeout");

  c_ack: cover property ($rose(sda_oe));
  c_timeout: cover property (low_cnt == TIMEOUT_CYC + 8);
  c_sqw: cover property ($rose(square_wave_pin));
endmodule // srtc_props

bind srtc_top srtc_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .clk(clk), .srst(srst), .ce(ce), .osc_clk(osc_clk), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .square_wave_pin(square_wave_pin), .wr_fifo_full(wr_fifo_full));

// [srtc_i2c_host.sv]
/* srtc_i2c_host.sv: two-wire bus master model.
   assumes: driven at negedge clk; sda resolved outside with a pull-up. */
`timescale 1ns/100ps
// ------------------------------------------------
// bus master
// ------------------------------------------------
module srtc_i2c_host (
  input wire clk, // system clock
  output logic scl, // bus clock
  output logic sda_rel, // high releases sda
  input wire sda // resolved sda
);
  int hp = 4; // half scl period in clk

  // idle bus, scl stands still between frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // start or repeated start
  task automatic start();
    sda_rel = 1'b1;
    wt(hp / 2);
    scl = 1'b1;
    wt(hp / 2);
    sda_rel = 1'b0;
    wt(hp / 2);
    scl = 1'b0;
    wt(hp / 2);
  endtask

  // stop leaves the bus idle
  task automatic stop();
    sda_rel = 1'b0;
    wt(hp / 2);
    scl = 1'b1;
    wt(hp / 2);
    sda_rel = 1'b1;
    wt(hp);
  endtask

  // data moves only in the low phase; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    wt(hp / 2);
    scl = 1'b1;
    wt(hp);
    r = sda;
    scl = 1'b0;
    wt(hp / 2);
  endtask

  // msb first, then the ninth pulse
  task automatic byte_io(input logic [7:0] tx, input logic ack_out,
                         output logic [7:0] rx, output logic ack_in);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_out, ack_in);
  endtask
endmodule // srtc_i2c_host

// [srtc_tb.sv]
/* srtc_tb.sv: self-checking bench with a byte-array register model.
   assumes: srtc_props bound to srtc_top; srtc_i2c_host compiled first. */
`timescale 1ns/100ps
// ------------------------------------------------
// testbench
// ------------------------------------------------
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic osc_clk = 1'b0;
  logic scl;
  logic sda_rel;
  wire sda_in;
  wire sda_oe;
  wire sda_out;
  wire square_wave_pin;
  wire wr_fifo_full;
  int n_errors = 0;
  int checks = 0;
  int mptr = 0;
  int rate_e[4] = '{0, 8, 16, 64};
  logic [7:0] mdl [64];
  logic [7:0] wq [$];
  logic [7:0] rx;
  logic ak;

  // open drain with pull-up; only an enabled low drive pulls the line down
  assign sda_in = sda_rel & !(sda_oe === 1'b1 && sda_out === 1'b0);

  srtc_top #(.TIMEOUT_CYC(2000)) dut (
    .clk(clk), .srst(srst), .ce(ce), .osc_clk(osc_clk), .scl_in(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .square_wave_pin(square_wave_pin), .wr_fifo_full(wr_fifo_full));
  srtc_i2c_host host (.clk(clk), .scl(scl), .sda_rel(sda_rel), .sda(sda_in));

  initial begin
    forever #20 clk = ~clk;
  end
  // oscillator sped up to 8 clk a period so counts stay short
  initial begin
    forever begin
      repeat (4) @(negedge clk);
      osc_clk = ~osc_clk;
    end
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] msk(input int a);
    case (a)
      1, 2: return 8'h7f;
      3: return 8'h07;
      4: return 8'h3f;
      5: return 8'h1f;
      7: return 8'hb3;
      default: return 8'hff;
    endcase
  endfunction

  // model write: fixed zeros dropped, stop flag clears only
  task automatic mwr(input int a, input logic [7:0] d);
    if (a == 7) d[5] = d[5] & mdl[7][5];
    mdl[a] = d & msk(a);
    if (a == 0 && d[7]) mdl[7][5] = 1'b1;
  endtask

  task automatic put(input logic [7:0] b, input logic e);
    host.byte_io(b, 1'b1, rx, ak);
    chk("ack bit", {7'h0, ak}, {7'h0, e});
  endtask

  // write the queued bytes from pointer p in one transfer
  task automatic wr(input logic [7:0] p);
    host.start();
    put(8'hd0, 1'b0);
    put(p, 1'b0);
    mptr = p;
    foreach (wq[i]) begin
      put(wq[i], 1'b0);
      mwr(mptr, wq[i]);
      mptr = (mptr + 1) % 64;
    end
    host.stop();
    wq = {};
  endtask

  // read n bytes; load the pointer first when p is not negative
  task automatic rd(input int p, input int n);
    host.start();
    if (p >= 0) begin
      put(8'hd0, 1'b0);
      put(8'(p), 1'b0);
      mptr = p;
      host.start();
    end
    put(8'hd1, 1'b0);
    for (int i = 0; i < n; i++) begin
      host.byte_io(8'hff, i == n - 1, rx, ak);
      chk("read byte", rx, mdl[mptr]);
      mptr = (mptr + 1) % 64;
    end
    host.stop();
  endtask

  // rising edges of the square wave over 64 oscillator periods
  task automatic edges(input int e);
    int n;
    logic prev;
    n = 0;
    prev = square_wave_pin;
    repeat (512) begin
      @(negedge clk);
      if (square_wave_pin && !prev) n++;
      prev = square_wave_pin;
    end
    chk("sqw edges", (n >= e - 1 && n <= e + 1) ? 8'(e) : 8'(n), 8'(e));
  endtask

  initial begin
    void'($urandom(32'h279c8a48));
    mdl[7] = 8'hb3;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk("sqw halted", {7'h0, square_wave_pin}, 8'h00);
    rd(7, 1); // control reset value
    for (int i = 0; i < 56; i++) begin
      wq.push_back(8'($urandom));
    end
    // ram, then wrap into every clock register in one go
    wq = {wq, 8'h00, 8'hd9, 8'h72, 8'h07, 8'h31, 8'h12, 8'h99, 8'h03};
    wr(8'h08);
    rd(0, 64);
    rd(-1, 1);
    for (int v = 1; v >= 0; v--) begin
      wq.push_back(8'(v << 7));
      wr(8'h07);
      chk("sqw level", {7'h0, square_wave_pin}, 8'(v));
    end
    for (int r = 0; r < 4; r++) begin
      wq.push_back(8'h10 | 8'(r));
      wr(8'h07);
      edges(rate_e[r]);
      // clock enable low must freeze even the fastest output
      if (r == 3) begin
        ce = 1'b0;
        edges(0);
        ce = 1'b1;
      end
    end
    wq.push_back(8'h20);
    wr(8'h07);
    rd(7, 1);
    wq.push_back(8'h80);
    wr(8'h00);
    rd(0, 8);
    wq.push_back(8'h33);
    wr(8'h07);
    edges(0);
    // scl held low after the address; the frame must be dropped
    host.start();
    put(8'hd0, 1'b0);
    host.wt(2100);
    put(8'h07, 1'b1);
    host.stop();
    host.start();
    put(8'hd2, 1'b1);
    host.stop();
    host.hp = 124;
    rd(3, 1);
    host.hp = 4;
    wrap_up();
  end
endmodule // testbench
